// *** logic/pog_pkg.sv ***
// shared constants, bus request carrier and decode helper for the port one block
package pog_pkg;

  // register indexes; byte address on the bus is four times the index
  localparam logic [15:0] POG_DIR_IDX   = 16'hFFC0;
  localparam logic [15:0] POG_DATA_IDX  = 16'hFFC2;

  // reset values and fixed read answers
  localparam logic [7:0]  POG_DIR_RST   = 8'h00;
  localparam logic [7:0]  POG_DATA_RST  = 8'h00;
  localparam logic [7:0]  POG_DIR_READ  = 8'hFF;
  localparam logic [7:0]  POG_PIN_RST   = 8'h00;

  // operating modes; mode 1 is the expanded mode
  localparam logic [1:0]  POG_MODE_EXP  = 2'h1;
  localparam logic [1:0]  POG_MODE_RST  = 2'h3;

  // htrans encoding for a non-sequential transfer
  localparam logic [1:0]  POG_HTRANS_NS = 2'h2;

  // request handed from the bus slave to the port core
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] idx;
    logic [7:0]  wdata;
  } pog_bus_req_t;

  function automatic logic pog_hit(input logic [15:0] idx, input logic [15:0] reg_idx);
    return idx == reg_idx;
  endfunction

endpackage

// *** logic/pog_pin_sync.sv ***
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module pog_pin_sync #(
  parameter int unsigned         WIDTH   = 8,
  parameter logic [WIDTH-1:0]    RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  // asynchronous level and its filtered copy
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] agree;

  // stage1 feeds stage2 only, so no logic sees a metastable value
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stage1_reg <= RST_VAL;
      stage2_reg <= RST_VAL;
      stage3_reg <= RST_VAL;
    end
    else if (ce_in)
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  assign agree = ~(stage2_reg ^ stage3_reg);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      sync_out <= RST_VAL;
    else if (ce_in)
      sync_out <= (agree & stage3_reg) | (~agree & sync_out);
  end

endmodule

// *** logic/pog_ahb_slave.sv ***
// ahb-lite slave front end: one wait state, write committed at the completing edge
`timescale 1ns/100ps
module pog_ahb_slave (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  ce_in,
  // ahb-lite
  input  wire logic                  hsel_in,
  input  wire logic [31:0]           haddr_in,
  input  wire logic [1:0]            htrans_in,
  input  wire logic                  hwrite_in,
  input  wire logic [31:0]           hwdata_in,
  input  wire logic                  hready_in,
  output logic                       hreadyout_out,
  output logic      [31:0]           hrdata_out,
  output logic                       hresp_out,
  // core side
  output pog_pkg::pog_bus_req_t      req_out,
  input  wire logic [7:0]            rdata_in
);

  typedef enum logic [1:0] {POG_S_IDLE, POG_S_WAIT, POG_S_DONE} pog_slv_state_t;

  pog_slv_state_t state_reg;
  logic           write_reg;
  logic [15:0]    idx_reg;
  logic           take;

  assign take = hsel_in && (htrans_in == pog_pkg::POG_HTRANS_NS) && hready_in;

  // the read is sampled one edge after the address so a write just completed is seen
  always_comb
  begin
    req_out.wr    = (state_reg == POG_S_DONE) && write_reg && hready_in;
    req_out.rd    = (state_reg == POG_S_WAIT) && !write_reg;
    req_out.idx   = idx_reg;
    req_out.wdata = hwdata_in[7:0];
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg     <= POG_S_IDLE;
      write_reg     <= 1'b0;
      idx_reg       <= 16'h0000;
      hreadyout_out <= 1'b1;
      hrdata_out    <= 32'h0000_0000;
      hresp_out     <= 1'b0;
    end
    else if (ce_in)
    begin
      hresp_out <= 1'b0;
      case (state_reg)
        POG_S_IDLE, POG_S_DONE:
        begin
          if (take)
          begin
            state_reg     <= POG_S_WAIT;
            write_reg     <= hwrite_in;
            idx_reg       <= haddr_in[17:2];
            hreadyout_out <= 1'b0;
          end
          else
            state_reg <= POG_S_IDLE;
        end
        POG_S_WAIT:
        begin
          state_reg     <= POG_S_DONE;
          hreadyout_out <= 1'b1;
          hrdata_out    <= write_reg ? 32'h0000_0000 : {24'h00_0000, rdata_in};
        end
        default:
        begin
          state_reg     <= POG_S_IDLE;
          hreadyout_out <= 1'b1;
        end
      endcase
    end
  end

endmodule

// *** logic/pog_port.sv ***
// port one: eight-pin gpio that doubles as low address output in expanded mode
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module pog_port (
  // clock, reset, clock enable
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  // operating mode strap and standby controls
  input  wire logic [1:0]  mode_in,
  input  wire logic        hw_standby_n_in,
  input  wire logic        sw_standby_in,
  // low address from the bus controller
  input  wire logic [7:0]  addr_low_in,
  // ahb-lite register bus
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic      [31:0] hrdata_out,
  output logic             hresp_out,
  // port pins
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe_out
);

  pog_pkg::pog_bus_req_t req;

  logic [7:0] dir_reg;
  logic [7:0] data_reg;
  logic [1:0] mode_reg;
  logic       mode_taken_reg;
  logic [7:0] pin_sync;
  logic       hw_standby_n_sync;
  logic       hw_standby;
  logic       dir_hit;
  logic       data_hit;
  logic [7:0] rd_value;
  logic [7:0] pin_next;
  logic [7:0] oe_next;

  pog_ahb_slave u_slave (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .ce_in         (ce_in),
    .hsel_in       (hsel_in),
    .haddr_in      (haddr_in),
    .htrans_in     (htrans_in),
    .hwrite_in     (hwrite_in),
    .hwdata_in     (hwdata_in),
    .hready_in     (hready_in),
    .hreadyout_out (hreadyout_out),
    .hrdata_out    (hrdata_out),
    .hresp_out     (hresp_out),
    .req_out       (req),
    .rdata_in      (rd_value)
  );

  // pins come from outside the clock domain
  pog_pin_sync #(
    .WIDTH   (8),
    .RST_VAL (8'h00)
  ) u_pin_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // hardware standby is a pin as well; its idle level is high
  pog_pin_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  ) u_hwsb_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .async_in (hw_standby_n_in),
    .sync_out (hw_standby_n_sync)
  );

  assign hw_standby = !hw_standby_n_sync;

  // upper address bits are not decoded, so the pair aliases every 256 kbyte
  assign dir_hit  = pog_pkg::pog_hit(req.idx, pog_pkg::POG_DIR_IDX);
  assign data_hit = pog_pkg::pog_hit(req.idx, pog_pkg::POG_DATA_IDX);

  // mode strap caught at the first enabled edge after reset release
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mode_reg       <= pog_pkg::POG_MODE_RST;
      mode_taken_reg <= 1'b0;
    end
    else if (ce_in && !mode_taken_reg)
    begin
      mode_reg       <= mode_in;
      mode_taken_reg <= 1'b1;
    end
  end

  // direction register; writes are blocked in software standby
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      dir_reg <= pog_pkg::POG_DIR_RST;
    else if (ce_in)
    begin
      if (hw_standby)
        dir_reg <= pog_pkg::POG_DIR_RST;
      else if (!sw_standby_in && req.wr && dir_hit)
        dir_reg <= req.wdata;
    end
  end

  // data register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      data_reg <= pog_pkg::POG_DATA_RST;
    else if (ce_in)
    begin
      if (hw_standby)
        data_reg <= pog_pkg::POG_DATA_RST;
      else if (!sw_standby_in && req.wr && data_hit)
        data_reg <= req.wdata;
    end
  end

  // read answer; unmapped indexes read zero
  always_comb
  begin
    if (dir_hit)
      rd_value = pog_pkg::POG_DIR_READ;
    else if (data_hit)
      rd_value = (dir_reg & data_reg) | (~dir_reg & pin_sync);
    else
      rd_value = 8'h00;
  end

  // pin drive value; only direction-one bits are driven
  always_comb
  begin
    oe_next = dir_reg;
    if (mode_reg == pog_pkg::POG_MODE_EXP)
      pin_next = addr_low_in & dir_reg;
    else
      pin_next = data_reg & dir_reg;
  end

  // pins are registered one cycle behind the registers; in software standby they freeze unless hardware standby clears them
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pin_out    <= pog_pkg::POG_PIN_RST;
      pin_oe_out <= pog_pkg::POG_PIN_RST;
    end
    else if (ce_in)
    begin
      if (hw_standby)
      begin
        pin_out    <= pog_pkg::POG_PIN_RST;
        pin_oe_out <= pog_pkg::POG_PIN_RST;
      end
      else if (!sw_standby_in)
      begin
        pin_out    <= pin_next;
        pin_oe_out <= oe_next;
      end
    end
  end

  // checks
  // bus checks assume ce_in stays high through a transfer; a frozen wait state would trip them

  dir_reads_ones_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && req.rd && dir_hit) |=> (hrdata_out == 32'h0000_00FF))
    else $error("direction register did not read all ones");

  dir_write_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && !hw_standby && !sw_standby_in && req.wr && dir_hit)
      |=> (dir_reg == $past(hwdata_in[7:0])))
    else $error("direction write not stored");

  data_write_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && !hw_standby && !sw_standby_in && req.wr && data_hit)
      |=> (data_reg == $past(hwdata_in[7:0])))
    else $error("data write not stored");

  hw_standby_clear_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && hw_standby) |=> (dir_reg == 8'h00 && data_reg == 8'h00 && pin_oe_out == 8'h00))
    else $error("hardware standby left state uncleared");

  sw_standby_hold_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && sw_standby_in && !hw_standby) |=> ($stable(dir_reg) && $stable(data_reg)))
    else $error("software standby changed a register");

  sw_standby_drive_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && sw_standby_in && !hw_standby) |=> ($stable(pin_oe_out) && $stable(pin_out)))
    else $error("software standby released the pins");

  mode1_address_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && !hw_standby && !sw_standby_in && mode_reg == pog_pkg::POG_MODE_EXP)
      |=> (pin_out == ($past(addr_low_in) & $past(dir_reg)) && pin_oe_out == $past(dir_reg)))
    else $error("expanded mode pin is not the address");

  single_chip_out_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && !hw_standby && !sw_standby_in && mode_reg != pog_pkg::POG_MODE_EXP)
      |=> (pin_out == ($past(data_reg) & $past(dir_reg)) && pin_oe_out == $past(dir_reg)))
    else $error("single-chip pin does not follow the data register");

  port_read_mix_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && req.rd && data_hit)
      |=> (hrdata_out[7:0] == (($past(dir_reg) & $past(data_reg)) | (~$past(dir_reg) & $past(pin_sync)))))
    else $error("port read mixes data and pins wrongly");

  unmapped_write_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && !hw_standby && req.wr && !dir_hit && !data_hit)
      |=> ($stable(dir_reg) && $stable(data_reg)))
    else $error("write to an unmapped address changed a register");

  wait_state_low_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && hsel_in && htrans_in == pog_pkg::POG_HTRANS_NS && hready_in) |=> !hreadyout_out)
    else $error("bus transfer taken without a wait state");

  wait_state_end_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && !hreadyout_out) |=> hreadyout_out)
    else $error("wait state lasted more than one cycle");

  undriven_low_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ((pin_out & ~pin_oe_out) == 8'h00))
    else $error("undriven pin shows a one");

  read_driven_bits_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && req.rd && data_hit)
      |=> ((hrdata_out[7:0] & $past(dir_reg)) == ($past(data_reg) & $past(dir_reg))))
    else $error("output bit read back something other than its data bit");

  mode_strap_hold_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && mode_taken_reg) |=> $stable(mode_reg))
    else $error("mode changed after it was caught");

  hw_standby_pins_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && hw_standby) |=> (pin_out == 8'h00))
    else $error("hardware standby left a pin value");

  unmapped_read_zero_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && req.rd && !dir_hit && !data_hit) |=> (hrdata_out == 32'h0000_0000))
    else $error("unmapped read returned nonzero data");

  oe_follows_dir_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && !hw_standby && !sw_standby_in)
      |=> (pin_oe_out == $past(dir_reg)))
    else $error("output enable does not follow the direction bits");

  read_keeps_state_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && req.rd && !hw_standby) |=> ($stable(dir_reg) && $stable(data_reg)))
    else $error("a read changed a register");

  sw_write_ignored_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && sw_standby_in && !hw_standby && req.wr)
      |=> ($stable(dir_reg) && $stable(data_reg)))
    else $error("write landed during software standby");

  mode1_no_data_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && !hw_standby && !sw_standby_in && mode_reg == pog_pkg::POG_MODE_EXP)
      |=> (((pin_out ^ $past(addr_low_in)) & $past(dir_reg)) == 8'h00))
    else $error("expanded mode pin shows something other than the address");

endmodule

// *** sim/pog_ext_dev.sv ***
// model of the external parts that share the port pins
`timescale 1ns/100ps
module pog_ext_dev (
  // clock
  input  wire logic       clk_in,
  // external drive request
  input  wire logic [7:0] drv_en_in,
  input  wire logic [7:0] drv_val_in,
  // port drive
  input  wire logic [7:0] pin_out_in,
  input  wire logic [7:0] pin_oe_in,
  // resolved pin level
  output logic      [7:0] pin_level_out
);
  // no pull-ups here: a pin nobody drives toggles, so the port's synchroniser never accepts it and a read returns its last settled level
  logic [7:0] float_reg = 8'h55;

  always @(posedge clk_in)
  begin
    float_reg <= ~float_reg;
  end

  assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & drv_en_in & drv_val_in)
                       | (~pin_oe_in & ~drv_en_in & float_reg);
endmodule

// *** sim/tb_port_one_gpio_addr_mux.sv ***
// register and pin tests of the port one block
`timescale 1ns/100ps
module tb_port_one_gpio_addr_mux;
  localparam logic [31:0] A_DIR = {14'h0000, pog_pkg::POG_DIR_IDX, 2'h0};
  localparam logic [31:0] A_DAT = {14'h0000, pog_pkg::POG_DATA_IDX, 2'h0};
  localparam logic [31:0] A_BAD = {14'h0000, 16'hFFC1, 2'h0};
  logic        clk_in, rst_n_in, hw_sb_n, sw_sb, hsel, hwrite, hrdy;
  logic [1:0]  mode, htrans;
  logic [7:0]  addr_low, drv_en, drv_val, pin_lvl, pin_out, pin_oe;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic        hresp;
  int          n_mismatch, total_checks;

  pog_port u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .mode_in(mode),
    .hw_standby_n_in(hw_sb_n), .sw_standby_in(sw_sb), .addr_low_in(addr_low), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hwdata_in(hwdata), .hready_in(hrdy),
    .hreadyout_out(hrdy), .hrdata_out(hrdata), .hresp_out(hresp), .pin_in(pin_lvl),
    .pin_out(pin_out), .pin_oe_out(pin_oe));
  pog_ext_dev u_ext (.clk_in(clk_in), .drv_en_in(drv_en), .drv_val_in(drv_val),
    .pin_out_in(pin_out), .pin_oe_in(pin_oe), .pin_level_out(pin_lvl));

  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      n_mismatch++;
    end
  endtask

  // ready is looked at mid-cycle, where it already holds the value the next edge samples
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(negedge clk_in);
      n++;
    end
    while (hrdy !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_mismatch++;
      end_of_test();
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= pog_pkg::POG_HTRANS_NS;
    hwrite <= wr;
    wait_rdy();
    @(posedge clk_in);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    @(posedge clk_in);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h00000000);
    check(rd, exp);
    check({31'h00000000, hresp}, 32'h00000000);
  endtask

  task automatic pins(input logic [7:0] oe, input logic [7:0] dv);
    @(negedge clk_in);
    check({24'h000000, pin_oe}, {24'h000000, oe});
    check({24'h000000, pin_out}, {24'h000000, dv});
    // hand back on a rising edge so the next stimulus lands there
    @(posedge clk_in);
  endtask

  task automatic do_reset(input logic [1:0] m);
    @(posedge clk_in);
    mode     <= m;
    rst_n_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
  endtask

  initial
  begin
    n_mismatch = 0;
    total_checks = 0;
    rst_n_in = 1'b0;
    mode = 2'h3;
    hw_sb_n = 1'b1;
    sw_sb = 1'b0;
    addr_low = 8'h00;
    drv_en = 8'hFF;
    drv_val = 8'h3C;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    do_reset(2'h3);
    repeat (6) @(posedge clk_in);
    pins(8'h00, 8'h00);
    rd_chk(A_DIR, 32'h000000FF);
    rd_chk(A_DAT, 32'h0000003C);
    drv_en <= 8'h0F;
    ahb(1'b1, A_DIR, 32'hFFFFFFF0);
    ahb(1'b1, A_DAT, 32'h123456A5);
    rd_chk(A_DIR, 32'h000000FF);
    rd_chk(A_DAT, 32'h000000AC);
    pins(8'hF0, 8'hA0);
    ahb(1'b1, A_BAD, 32'h000000FF);
    rd_chk(A_BAD, 32'h00000000);
    rd_chk(A_DAT, 32'h000000AC);
    sw_sb <= 1'b1;
    ahb(1'b1, A_DAT, 32'h00000000);
    ahb(1'b1, A_DIR, 32'h00000000);
    pins(8'hF0, 8'hA0);
    sw_sb <= 1'b0;
    rd_chk(A_DAT, 32'h000000AC);
    ahb(1'b1, A_DAT, 32'h0000005A);
    pins(8'hF0, 8'hA0);
    pins(8'hF0, 8'h50);
    drv_en <= 8'hFF;
    hw_sb_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    pins(8'h00, 8'h00);
    hw_sb_n <= 1'b1;
    repeat (6) @(posedge clk_in);
    rd_chk(A_DAT, 32'h0000003C);
    ahb(1'b1, A_DIR, 32'h000000FF);
    rd_chk(A_DAT, 32'h00000000);
    do_reset(pog_pkg::POG_MODE_EXP);
    drv_en <= 8'hF0;
    drv_val <= 8'h30;
    addr_low <= 8'h5A;
    ahb(1'b1, A_DAT, 32'h000000FF);
    pins(8'h00, 8'h00);
    ahb(1'b1, A_DIR, 32'h0000000F);
    @(posedge clk_in);
    pins(8'h0F, 8'h0A);
    addr_low <= 8'hC3;
    pins(8'h0F, 8'h0A);
    pins(8'h0F, 8'h03);
    rd_chk(A_DAT, 32'h0000003F);
    end_of_test();
  end
endmodule
